// *** rtl/adc_fifo_pkg.sv ***
/*
 Constants for the ADC sample FIFO control block: register map, field
 positions, reset values and flush timing. Assumes a 125 MHz bus clock.
*/
package adc_fifo_pkg;
   localparam logic [7:0]  CTRL_OFS   = 8'h20;  // sample_fifo_control
   localparam logic [7:0]  SYNC_OFS   = 8'h24;  // sync and coding control
   localparam logic [7:0]  DATA_OFS   = 8'h30;  // FIFO read port
   localparam logic [7:0]  COUNT_OFS  = 8'h34;  // fill count
   localparam int          DEPTH      = 262144;
   localparam logic [18:0] DEPTH_CNT  = 19'h40000;
   localparam logic [18:0] LIMIT_RST  = 19'h3FFFE;
   localparam int          EN_BIT     = 19;
   localparam int          FLUSH_BIT  = 20;
   localparam int          WID_LO     = 21;
   localparam int          TAG_BIT    = 23;
   localparam int          OVR_BIT    = 24;
   localparam int          UND_BIT    = 25;
   localparam int          SY_PULSE   = 0;
   localparam int          SY_EN      = 1;
   localparam int          SY_RISE    = 2;
   localparam int          SY_OB      = 3;
   localparam int          SY_SETTLED = 4;
   localparam int          CLK_MHZ    = 125;
   localparam int          FLUSH_US   = 5000;  // pipeline drain, under 10 ms
   localparam int          FLUSH_CYC  = FLUSH_US * CLK_MHZ;
   typedef enum logic {FL_IDLE, FL_BUSY} flush_t;
endpackage

// *** rtl/adc_sample_fifo_control.sv ***
/*
 ADC sample FIFO control: formats and stores ADC samples, serves them to
 an APB master one word per read, flags fill level, clears on request.
 Assumes the sample stream and board_init are synchronous to pclk.
*/
`timescale 1ns/1ps
// Summary of operation
// - Offset binary when coding bit high (default), two's complement when low.
// - 16-bit zero is 8000h offset binary, 0000h two's complement.
// - Level flag high while stored count exceeds the limit.
// - Level event on rising or falling flag edge, software selected.
// - With limit zero, flag falling edge gives a buffer-empty event.
// - Limit sits in bits 18..0, read/write, reset 0003FFFEh.
// - Intake bit admits samples; clearing stops intake, stored data stays.
// - Enable and disable act only at sample set boundaries.
// - Flush empties FIFO, holds for drain time, self-clears, reads high.
// - Width field selects 16, 18, 20 or 24 data bits.
// - Tag suppress writes zero channel tags.
// - Sticky overflow and underflow flags, cleared by writing low.
// - Sync pulse with flush-on-sync enabled clears the FIFO.
// - Fill count register reports zero to 262144.
// - 262144-word FIFO read at one address; empty read undefined.
// - Word holds zero nibble, tag in 27..24, pad, right-justified data.
// - Two's complement pads with sign extension.
// - Channel 00 first, highest active channel last in each set.
module adc_sample_fifo_control
   import adc_fifo_pkg::*;
#(
   parameter int FLUSH_CYCLES = FLUSH_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        board_init,
   input  wire logic        ext_clear,
   input  wire logic        s_valid,
   input  wire logic        s_last,
   input  wire logic [3:0]  s_chan,
   input  wire logic [23:0] s_data,
   output logic             fill_level_flag,
   output logic             level_event,
   output logic             empty_event,
   output logic             inputs_settled_flag
);
   typedef struct packed {
      logic [18:0] limit;
      logic        en;
      logic [1:0]  wid;
      logic        tag_off;
      logic        ovr;
      logic        und;
      logic        sync_en;
      logic        rise_sel;
      logic        ob;
      flush_t      fst;
      logic [19:0] fcnt;
      logic [17:0] wptr;
      logic [17:0] rptr;
      logic [18:0] count;
      logic        mid;
      logic        active;
      logic        flag;
      logic        lvl_evt;
      logic        emp_evt;
      logic        settled;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } state_t;

   state_t      s_q;
   state_t      s_d;
   logic [27:0] mem [DEPTH];
   logic [27:0] wword;
   logic [23:0] fmt;
   logic        push;
   logic        pop;
   logic        push_ok;
   logic        pop_ok;
   logic        full;
   logic        empty;
   logic        setup;
   logic        wr;
   logic        gate;

   // Coding and width; two's complement flips the MSB and sign-extends
   always_comb begin
      case (s_q.wid)
         2'd0: fmt = {8'h00, s_data[23:8]};
         2'd1: fmt = {6'h00, s_data[23:6]};
         2'd2: fmt = {4'h0, s_data[23:4]};
         default: fmt = s_data;
      endcase
      if (!s_q.ob) begin
         case (s_q.wid)
            2'd0: fmt = {{9{~s_data[23]}}, s_data[22:8]};
            2'd1: fmt = {{7{~s_data[23]}}, s_data[22:6]};
            2'd2: fmt = {{5{~s_data[23]}}, s_data[22:4]};
            default: fmt = {~s_data[23], s_data[22:0]};
         endcase
      end
      wword = {(s_q.tag_off ? 4'h0 : s_chan), fmt};
   end

   // Main next-state logic
   always_comb begin
      s_d     = s_q;
      full    = (s_q.count == DEPTH_CNT);
      empty   = (s_q.count == 19'h00000);
      setup   = psel & ~penable;
      wr      = psel & penable & s_q.ready & pwrite;
      // Gate changes only between sets, so a set is never split
      gate    = s_q.mid ? s_q.active : s_q.en;
      push    = s_valid & gate & (s_q.fst == FL_IDLE);
      pop     = setup & ~pwrite & (paddr == DATA_OFS);
      push_ok = push & ~full;
      pop_ok  = pop & ~empty;
      s_d.active = gate;
      if (s_valid) begin
         s_d.mid = ~s_last;
      end
      // Pointers and count; push and pop together leave count alone
      if (push_ok) begin
         s_d.wptr = s_q.wptr + 18'd1;
      end
      if (pop_ok) begin
         s_d.rptr = s_q.rptr + 18'd1;
      end
      case ({push_ok, pop_ok})
         2'b10: s_d.count = s_q.count + 19'd1;
         2'b01: s_d.count = s_q.count - 19'd1;
         default: s_d.count = s_q.count;
      endcase
      // APB: answer in access phase, decoded during setup
      s_d.ready = setup;
      s_d.err   = 1'b0;
      if (setup) begin
         s_d.rdata = 32'h0000_0000;
         case (paddr)
            CTRL_OFS: s_d.rdata = {6'h00, s_q.und, s_q.ovr, s_q.tag_off, s_q.wid,
                                   (s_q.fst == FL_BUSY), s_q.en, s_q.limit};
            SYNC_OFS: s_d.rdata = {27'h0, s_q.settled, s_q.ob, s_q.rise_sel,
                                   s_q.sync_en, 1'b0};
            DATA_OFS: s_d.rdata = {4'h0, mem[s_q.rptr]};
            COUNT_OFS: s_d.rdata = {13'h0000, s_q.count};
            default: s_d.err = 1'b1;
         endcase
      end
      // Register writes, taken at the access edge
      if (wr && paddr == CTRL_OFS) begin
         s_d.limit   = pwdata[18:0];
         s_d.en      = pwdata[EN_BIT];
         s_d.wid     = pwdata[WID_LO+1:WID_LO];
         s_d.tag_off = pwdata[TAG_BIT];
         if (!pwdata[OVR_BIT]) begin
            s_d.ovr = 1'b0;
         end
         if (!pwdata[UND_BIT]) begin
            s_d.und = 1'b0;
         end
      end
      if (wr && paddr == SYNC_OFS) begin
         s_d.sync_en  = pwdata[SY_EN];
         s_d.rise_sel = pwdata[SY_RISE];
         s_d.ob       = pwdata[SY_OB];
      end
      // Sticky flags; a new event beats a same-cycle clear
      if (push & full) begin
         s_d.ovr = 1'b1;
      end
      if (pop & empty) begin
         s_d.und = 1'b1;
      end
      // Flush: local write, sync pulse or external request
      if ((wr && paddr == CTRL_OFS && pwdata[FLUSH_BIT])
          || (wr && paddr == SYNC_OFS && pwdata[SY_PULSE] && s_q.sync_en)
          || ext_clear) begin
         s_d.fst  = FL_BUSY;
         s_d.fcnt = 20'h00000;
      end else begin
         case (s_q.fst)
            FL_BUSY: begin
               s_d.fcnt = s_q.fcnt + 20'h00001;
               if (s_q.fcnt == 20'(FLUSH_CYCLES - 1)) begin
                  s_d.fst = FL_IDLE;
               end
            end
            default: s_d.fst = FL_IDLE;
         endcase
      end
      // Held empty while the pipeline drains
      if (s_d.fst == FL_BUSY) begin
         s_d.wptr  = 18'h00000;
         s_d.rptr  = 18'h00000;
         s_d.count = 19'h00000;
      end
      s_d.settled = (s_d.fst == FL_IDLE);
      // Board init restores defaults and empties the FIFO
      if (board_init) begin
         s_d.limit   = LIMIT_RST;
         s_d.en      = 1'b0;
         s_d.wid     = 2'd0;
         s_d.tag_off = 1'b0;
         s_d.ovr     = 1'b0;
         s_d.und     = 1'b0;
         s_d.sync_en = 1'b0;
         s_d.rise_sel = 1'b0;
         s_d.ob      = 1'b1;
         s_d.wptr    = 18'h00000;
         s_d.rptr    = 18'h00000;
         s_d.count   = 19'h00000;
      end
      // Level flag and its edge events, from the next count
      s_d.flag    = (s_d.count > s_d.limit);
      s_d.lvl_evt = s_q.rise_sel ? (s_d.flag & ~s_q.flag)
                                 : (~s_d.flag & s_q.flag);
      s_d.emp_evt = (s_d.limit == 19'h00000) & s_q.flag & ~s_d.flag;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q          <= '0;
         s_q.limit    <= LIMIT_RST;
         s_q.ob       <= 1'b1;
         s_q.settled  <= 1'b1;
         s_q.fst      <= FL_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Sample store; no reset, contents are don't-care until written
   always_ff @(posedge pclk) begin
      if (push_ok) begin
         mem[s_q.wptr] <= wword;
      end
   end

   assign prdata              = s_q.rdata;
   assign pready              = s_q.ready;
   assign pslverr             = s_q.err;
   assign fill_level_flag     = s_q.flag;
   assign level_event         = s_q.lvl_evt;
   assign empty_event         = s_q.emp_evt;
   assign inputs_settled_flag = s_q.settled;

   chk_flag_level: assert property (@(posedge pclk) disable iff (!presetn)
      fill_level_flag == (s_q.count > s_q.limit)) else $error("level flag wrong");
   chk_count_range: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.count <= DEPTH_CNT) else $error("count above depth");
   chk_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      push && full && !board_init |=> s_q.ovr) else $error("overflow not set");
   chk_und_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      pop && empty && !board_init |=> s_q.und) else $error("underflow not set");
   chk_both_hold: assert property (@(posedge pclk) disable iff (!presetn)
      push_ok && pop_ok && s_d.fst == FL_IDLE && !board_init |=> $stable(s_q.count))
      else $error("count moved on push and pop");
   chk_empty_event: assert property (@(posedge pclk) disable iff (!presetn)
      empty_event |-> s_q.limit == 19'h00000 && !fill_level_flag && $past(fill_level_flag))
      else $error("bad empty event");
   chk_flush_empty: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.fst == FL_BUSY |-> s_q.count == 19'h00000 && !inputs_settled_flag)
      else $error("FIFO not empty in flush");
   chk_gate_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.mid && !s_q.active |-> !push) else $error("intake opened mid set");
   chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready) else $error("APB answer timing");
   // Intake and clear checks look at stored state, not at the gate term; format checks key on push_ok, which includes it
   chk_intake_off: assert property (@(posedge pclk) disable iff (!presetn)
      s_valid && !s_q.mid && !s_q.en && !pop_ok |=> s_q.count <= $past(s_q.count))
      else $error("sample taken while intake off");
   chk_width_pad: assert property (@(posedge pclk) disable iff (!presetn)
      push_ok && s_q.ob && s_q.wid == 2'd0 |-> wword[23:16] == 8'h00)
      else $error("pad not zero at 16 bits");
   chk_sign_pad: assert property (@(posedge pclk) disable iff (!presetn)
      push_ok && !s_q.ob && s_q.wid == 2'd0 |-> wword[23:16] == {8{wword[15]}})
      else $error("pad not sign extension");
   chk_tag_zero: assert property (@(posedge pclk) disable iff (!presetn)
      push_ok && s_q.tag_off |-> wword[27:24] == 4'h0) else $error("tag not suppressed");
   chk_flush_start: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == CTRL_OFS && pwdata[FLUSH_BIT]
      |=> s_q.fst == FL_BUSY && s_q.count == 19'h00000) else $error("flush did not start");
   chk_ext_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ext_clear |=> s_q.fst == FL_BUSY && !inputs_settled_flag)
      else $error("external clear not seen");
   chk_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == SYNC_OFS && pwdata[SY_PULSE] && s_q.sync_en
      |=> s_q.fst == FL_BUSY && s_q.count == 19'h00000) else $error("sync did not clear");
   // Checks on what software and the event logic see
   chk_ctrl_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite && paddr == CTRL_OFS |-> prdata[31:26] == 6'h00)
      else $error("reserved control bits set");
   chk_level_dir: assert property (@(posedge pclk) disable iff (!presetn)
      level_event |-> fill_level_flag == $past(s_q.rise_sel)
         && fill_level_flag != $past(fill_level_flag)) else $error("level event on wrong edge");
endmodule // adc_sample_fifo_control

// *** verif/adc_stream_model.sv ***
/*
 Upstream sample stream model: sends whole sample sets, channel 00 first.
 Assumes it is called from the bench process and driven off pclk.
*/
`timescale 1ns/1ps
module adc_stream_model (
   input  wire logic        pclk,
   output logic             s_valid,
   output logic             s_last,
   output logic [3:0]       s_chan,
   output logic [23:0]      s_data
);
   // Idle stream at time zero
   initial begin
      s_valid = 1'b0;
      s_last  = 1'b0;
      s_chan  = 4'h0;
      s_data  = 24'h000000;
   end

   // One set per call; idle data shows the inverse so nothing stale matches
   task automatic send_set(input int n, input logic [23:0] d);
      for (int c = 0; c < n; c++) begin
         @(posedge pclk);
         s_valid <= 1'b1;
         s_last  <= (c == n - 1);   // Highest channel closes the set
         s_chan  <= c[3:0];         // Ascending from channel 00
         s_data  <= d;
      end
      @(posedge pclk);
      s_valid <= 1'b0;
      s_last  <= 1'b0;
      s_chan  <= ~s_chan;
      s_data  <= ~d;
   endtask
endmodule // adc_stream_model

// *** verif/test_adc_sample_fifo_control.sv ***
/*
 Self-checking bench for the ADC sample FIFO control block over APB.
 Assumes a short flush time parameter and the stream model beside it.
*/
`timescale 1ns/1ps
module test_adc_sample_fifo_control;
   import adc_fifo_pkg::*;
   localparam int          FL = 20;          // Short flush keeps run brief
   localparam logic [23:0] DV = 24'h7FFFC3;  // One LSB below zero at 16 bits
   localparam logic [31:0] FB = 32'h1 << FLUSH_BIT;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        board_init, ext_clear, s_valid, s_last, serr;
   logic        fill_level_flag, level_event, empty_event, inputs_settled_flag;
   logic [7:0]  paddr;
   logic [3:0]  s_chan;
   logic [23:0] s_data;
   logic [31:0] pwdata, prdata, rdat;
   int          n_fail = 0, cmp_count = 0, n_lev = 0, n_emp = 0, w;

   adc_sample_fifo_control #(.FLUSH_CYCLES(FL)) adc_sample_fifo_control_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .board_init(board_init),
      .ext_clear(ext_clear), .s_valid(s_valid), .s_last(s_last), .s_chan(s_chan),
      .s_data(s_data), .fill_level_flag(fill_level_flag), .level_event(level_event),
      .empty_event(empty_event), .inputs_settled_flag(inputs_settled_flag));
   adc_stream_model adc_stream_model_inst (.pclk(pclk), .s_valid(s_valid),
      .s_last(s_last), .s_chan(s_chan), .s_data(s_data));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Count event pulses as sampled at each edge
   always @(posedge pclk) begin
      if (level_event === 1'b1) n_lev++;
      if (empty_event === 1'b1) n_emp++;
   end

   task automatic tally_and_finish;
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Setup then access; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle limit here; the watchdog ends a hung slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      serr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   function automatic logic [31:0] cw(logic [18:0] lim, logic en, logic [1:0] wd, logic ts);
      return {8'h00, ts, wd, 1'b0, en, lim};
   endfunction
   // Expected word from width, coding, tag suppress, channel and raw sample
   function automatic logic [31:0] fmt(logic [1:0] wd, logic ob, logic ts, logic [3:0] ch,
                                        logic [23:0] d);
      logic [23:0] v;
      int          nb;
      nb = (wd == 2'h0) ? 16 : (wd == 2'h1) ? 18 : (wd == 2'h2) ? 20 : 24;
      v = d >> (24 - nb);
      if (!ob) begin
         v[nb-1] = ~v[nb-1];
         for (int i = nb; i < 24; i++) v[i] = v[nb-1];
      end
      return {4'h0, ts ? 4'h0 : ch, v};
   endfunction

   // Hang guard, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, board_init, ext_clear} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(CTRL_OFS, 32'h0003_FFFE);
      rdc(COUNT_OFS, 32'h0);
      rdc(SYNC_OFS, 32'h18);
      wr(8'h40, 32'h1);
      chk({31'h0, serr}, 32'h1);
      wr(CTRL_OFS, 32'hFC00_0005);
      rdc(CTRL_OFS, 32'h0000_0005);
      // Every width, both codings, tag on and off
      for (int k = 0; k < 8; k++) begin
         wr(SYNC_OFS, {28'h0, ~k[2], 3'h0});
         wr(CTRL_OFS, cw(19'h2, 1'b1, k[1:0], k[0]));
         adc_stream_model_inst.send_set(3, DV);
         rdc(COUNT_OFS, 32'h3);
         chk({31'h0, fill_level_flag}, 32'h1);
         for (int c = 0; c < 3; c++)
            rdc(DATA_OFS, fmt(k[1:0], ~k[2], k[0], c[3:0], DV));
         chk({31'h0, fill_level_flag}, 32'h0);
      end
      apb(1'b0, DATA_OFS, 32'h0);
      rdc(CTRL_OFS, cw(19'h2, 1'b1, 2'h3, 1'b1) | (32'h1 << UND_BIT));
      wr(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0));
      rdc(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0));
      // Falling then rising edge select, limit zero
      wr(SYNC_OFS, 32'h08);
      n_lev = 0;
      n_emp = 0;
      adc_stream_model_inst.send_set(1, DV);
      rdc(DATA_OFS, fmt(2'h0, 1'b1, 1'b0, 4'h0, DV));
      wr(SYNC_OFS, 32'h0C);
      adc_stream_model_inst.send_set(1, DV);
      rdc(DATA_OFS, fmt(2'h0, 1'b1, 1'b0, 4'h0, DV));
      // Let the last pulse reach the counters before comparing
      @(posedge pclk);
      chk(n_lev, 32'h2);
      chk(n_emp, 32'h2);
      // Disable and enable written in mid-set act on set boundaries
      fork
         adc_stream_model_inst.send_set(8, DV);
         wr(CTRL_OFS, cw(19'h0, 1'b0, 2'h0, 1'b0));
      join
      adc_stream_model_inst.send_set(2, DV);
      rdc(COUNT_OFS, 32'h8);
      fork
         adc_stream_model_inst.send_set(4, DV);
         wr(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0));
      join
      adc_stream_model_inst.send_set(1, DV);
      rdc(COUNT_OFS, 32'h9);
      // Local flush, external clear, then clear on host sync
      wr(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0) | FB);
      rdc(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0) | FB);
      repeat (FL + 4) @(posedge pclk);
      rdc(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0));
      rdc(COUNT_OFS, 32'h0);
      ext_clear <= 1'b1;
      @(posedge pclk);
      ext_clear <= 1'b0;
      rdc(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0) | FB);
      repeat (FL + 4) @(posedge pclk);
      adc_stream_model_inst.send_set(1, DV);
      wr(SYNC_OFS, 32'h0A);
      wr(SYNC_OFS, 32'h0B);
      rdc(CTRL_OFS, cw(19'h0, 1'b1, 2'h0, 1'b0) | FB);
      w = 0;
      while (inputs_settled_flag !== 1'b1 && w < 100) begin
         @(posedge pclk);
         w++;
      end
      chk({31'h0, inputs_settled_flag}, 32'h1);
      wr(SYNC_OFS, 32'h08);
      rdc(COUNT_OFS, 32'h0);
      board_init <= 1'b1;
      @(posedge pclk);
      board_init <= 1'b0;
      rdc(CTRL_OFS, 32'h0003_FFFE);
      rdc(SYNC_OFS, 32'h18);
      tally_and_finish;
   end
endmodule // test_adc_sample_fifo_control
